// [verilog/cies_core.sv]
// Execution unit for status alternate_space_move, privileged alternate_space_move, multiply, negate, OR, reset and rotate
`timescale 1ns/100ps
// Contract
// - Status read copies status only in supervisor state, else traps
// - Status write loads status only in supervisor state, else traps unchanged
// - User stack pointer alternate_space_move either way in supervisor state only, else trap
// - Alternate space move uses function codes in supervisor state, user traps
// - Multi register move stores or loads a selected register list
// - Quick move writes a small sign-extended immediate into a data register
// - Multiply word gives 32-bit product; long keeps low 32 bits
// - Long multiply can write full 64-bit product into high and low registers
// - Negate writes zero minus operand
// - Negate with extend writes zero minus operand minus extend flag
// - OR writes source OR destination into destination
// - Immediate OR writes immediate OR destination back
// - Immediate OR to status only in supervisor, user traps leaving status
// - Reset pulses external reset output only in supervisor state
// - Rotate by register or immediate count, or by one for memory
module cies_core #(
    parameter int RESET_CYC = cies_pkg::RESET_OUT_CYC
) (
    input  wire logic        clk,         // Clock, 20 MHz
    input  wire logic        rst,         // Asynchronous reset, active high
    input  wire logic        ce,          // Clock enable, freezes all state when low
    input  wire logic        cmd_valid,   // Command request pulse
    input  wire logic [4:0]  cmd_op,      // Operation code
    input  wire logic [31:0] src_data,    // Source operand or immediate
    input  wire logic [31:0] dst_data,    // Destination operand
    input  wire logic [2:0]  reg_sel,     // Register index for alternate_space_move
    input  wire logic [2:0]  reg_hi_sel,  // High register of a 64-bit product
    input  wire logic        mul_full,    // Long multiply writes 64-bit pair
    input  wire logic [7:0]  reg_list,    // Register list for multi move
    input  wire logic [5:0]  rot_count,   // Rotate count
    input  wire logic        rot_mem,     // Memory rotate, count of one
    input  wire logic [2:0]  fc_in,       // Function code value to load
    input  wire logic        fc_we_src,   // Load source function code
    input  wire logic        fc_we_dst,   // Load destination function code
    output logic             busy,        // Command in progress
    output logic             done,        // Result valid pulse
    output logic [31:0]      result,      // Result word
    output logic [31:0]      result_hi,   // High half of a 64-bit product
    output logic             trap,        // Privilege trap pulse
    output logic [7:0]       trap_vector, // Trap vector number
    output logic [15:0]      status_reg,  // Status register
    output logic [31:0]      user_stack_pointer, // User stack pointer
    output logic [31:0]      addr_reg_out,   // Address register read value
    output logic [2:0]       mem_fc,         // Function code of memory access
    output logic             mem_we,         // Memory write pulse
    output logic             mem_re,         // Memory read pulse
    output logic [2:0]       mem_reg_idx,    // Register of multi move beat
    output logic             ext_reset       // External reset output, active high
);
    logic [15:0]           status_ff, nxt_status;
    logic [31:0]           usp_ff, nxt_usp;
    logic [31:0]           an_ff [cies_pkg::NREG];
    logic [31:0]           nxt_an [cies_pkg::NREG];
    logic [2:0]            sfc_ff, nxt_sfc, dfc_ff, nxt_dfc;
    cies_pkg::cies_state_e st_ff, nxt_st;
    logic [31:0]           res_ff, nxt_res, rhi_ff, nxt_rhi, anout_ff, nxt_anout;
    logic                  done_ff, nxt_done, trap_ff, nxt_trap;
    logic [7:0]            vec_ff, nxt_vec, list_ff, nxt_list;
    logic [2:0]            fc_ff, nxt_fc, idx_ff, nxt_idx;
    logic                  we_ff, nxt_we, re_ff, nxt_re, rst_o_ff, nxt_rst_o;
    logic [12:0]           cnt_ff, nxt_cnt;
    logic [63:0]           prod_ff, nxt_prod;
    logic                  full_ff, nxt_full, ld_ff, nxt_ld, busy_ff, nxt_busy;
    logic [31:0]           rot_out;
    logic [5:0]            rot_amt;
    logic                  sup;
    logic                  priv_op;
    cies_pkg::cies_op_e    op;

    assign op      = cies_pkg::cies_op_e'(cmd_op);
    assign sup     = status_ff[cies_pkg::SUP_BIT];
    assign rot_amt = rot_mem ? 6'h01 : rot_count;

    cies_rotator #(.W(32)) u_rot (
        .din   (dst_data),
        .count (rot_amt),
        .left  (op == cies_pkg::OP_ROL),
        .dout  (rot_out)
    );

    // Privileged operation decode
    always_comb begin
        case (op)
            cies_pkg::OP_SR_READ, cies_pkg::OP_SR_WRITE, cies_pkg::OP_USP_TO_AN,
            cies_pkg::OP_AN_TO_USP, cies_pkg::OP_ALT_WRITE, cies_pkg::OP_ALT_READ,
            cies_pkg::OP_ORI_SR, cies_pkg::OP_RESET: priv_op = 1'b1;
            default: priv_op = 1'b0;
        endcase
    end

    // Next state and datapath
    always_comb begin
        nxt_status = status_ff;
        nxt_usp    = usp_ff;
        nxt_an     = an_ff;
        nxt_sfc    = fc_we_src ? fc_in : sfc_ff;
        nxt_dfc    = fc_we_dst ? fc_in : dfc_ff;
        nxt_st     = st_ff;
        nxt_res    = res_ff;
        nxt_rhi    = rhi_ff;
        nxt_anout  = an_ff[reg_sel];
        nxt_done   = 1'b0;
        nxt_trap   = 1'b0;
        nxt_vec    = vec_ff;
        nxt_list   = list_ff;
        nxt_fc     = fc_ff;
        nxt_idx    = idx_ff;
        nxt_we     = 1'b0;
        nxt_re     = 1'b0;
        nxt_rst_o  = rst_o_ff;
        nxt_cnt    = cnt_ff;
        nxt_prod   = prod_ff;
        nxt_full   = full_ff;
        nxt_ld     = ld_ff;
        case (st_ff)
            cies_pkg::ST_IDLE: begin
                if (cmd_valid && priv_op && !sup) begin
                    nxt_trap = 1'b1;
                    nxt_vec  = cies_pkg::PRIV_VECTOR;
                end else if (cmd_valid) begin
                    nxt_done = 1'b1;
                    case (op)
                        cies_pkg::OP_SR_READ:  nxt_res = {16'h0000, status_ff};
                        cies_pkg::OP_SR_WRITE: nxt_status = src_data[15:0];
                        cies_pkg::OP_USP_TO_AN: nxt_an[reg_sel] = usp_ff;
                        cies_pkg::OP_AN_TO_USP: nxt_usp = an_ff[reg_sel];
                        cies_pkg::OP_ALT_WRITE: begin
                            nxt_res = src_data;
                            nxt_fc  = dfc_ff;
                            nxt_we  = 1'b1;
                        end
                        cies_pkg::OP_ALT_READ: begin
                            nxt_res = src_data;
                            nxt_fc  = sfc_ff;
                            nxt_re  = 1'b1;
                        end
                        cies_pkg::OP_MULTI_ST, cies_pkg::OP_MULTI_LD: begin
                            nxt_done = 1'b0;
                            nxt_list = reg_list;
                            nxt_ld   = (op == cies_pkg::OP_MULTI_LD);
                            nxt_st   = cies_pkg::ST_MULTI;
                        end
                        cies_pkg::OP_QUICK: nxt_res = {{24{src_data[7]}}, src_data[7:0]};
                        cies_pkg::OP_UNSIGNED_MULTIPLY_W: nxt_prod = {32'h0000_0000,
                            32'(src_data[15:0] * dst_data[15:0])};
                        cies_pkg::OP_SIGNED_MULTIPLY_W: nxt_prod = {32'h0000_0000,
                            32'($signed(src_data[15:0]) * $signed(dst_data[15:0]))};
                        cies_pkg::OP_UNSIGNED_MULTIPLY_L, cies_pkg::OP_UNSIGNED_MULTIPLY_LL:
                            nxt_prod = 64'({32'h0000_0000, src_data} * {32'h0000_0000, dst_data});
                        cies_pkg::OP_SIGNED_MULTIPLY_L, cies_pkg::OP_SIGNED_MULTIPLY_LL:
                            nxt_prod = 64'($signed({{32{src_data[31]}}, src_data})
                                * $signed({{32{dst_data[31]}}, dst_data}));
                        cies_pkg::OP_NEG: nxt_res = 32'(32'h0000_0000 - dst_data);
                        cies_pkg::OP_NEGATE_EXTEND_OP: nxt_res = 32'(32'h0000_0000 - dst_data
                            - {31'h0, status_ff[cies_pkg::XFLAG_BIT]});
                        cies_pkg::OP_OR: nxt_res = src_data | dst_data;
                        cies_pkg::OP_ORI: nxt_res = src_data | dst_data;
                        cies_pkg::OP_ORI_SR: nxt_status = status_ff | src_data[15:0];
                        cies_pkg::OP_RESET: begin
                            nxt_done  = 1'b0;
                            nxt_rst_o = 1'b1;
                            nxt_cnt   = 13'(RESET_CYC - 1);
                            nxt_st    = cies_pkg::ST_RESET;
                        end
                        cies_pkg::OP_ROL, cies_pkg::OP_ROR: nxt_res = rot_out;
                        default: nxt_done = 1'b1;
                    endcase
                    if (op >= cies_pkg::OP_UNSIGNED_MULTIPLY_W && op <= cies_pkg::OP_SIGNED_MULTIPLY_LL) begin
                        nxt_done = 1'b0;
                        nxt_full = mul_full && (op == cies_pkg::OP_UNSIGNED_MULTIPLY_LL
                            || op == cies_pkg::OP_SIGNED_MULTIPLY_LL);
                        nxt_cnt  = 13'(cies_pkg::MUL_CYC - 1);
                        nxt_st   = cies_pkg::ST_MUL;
                    end
                end
            end
            cies_pkg::ST_MUL: begin
                if (cnt_ff == 13'h0000) begin
                    nxt_res  = prod_ff[31:0];
                    nxt_rhi  = full_ff ? prod_ff[63:32] : 32'h0000_0000;
                    nxt_done = 1'b1;
                    nxt_st   = cies_pkg::ST_IDLE;
                end else begin
                    nxt_cnt = 13'(cnt_ff - 13'h0001);
                end
            end
            cies_pkg::ST_MULTI: begin
                if (list_ff == 8'h00) begin
                    nxt_done = 1'b1;
                    nxt_st   = cies_pkg::ST_IDLE;
                end else begin
                    for (int i = cies_pkg::NREG - 1; i >= 0; i--) begin
                        if (list_ff[i]) begin
                            nxt_idx = 3'(i);
                        end
                    end
                    nxt_list[nxt_idx] = 1'b0;
                    nxt_we = !ld_ff;
                    nxt_re = ld_ff;
                    nxt_fc = 3'h5;
                end
            end
            cies_pkg::ST_RESET: begin
                if (cnt_ff == 13'h0000) begin
                    nxt_rst_o = 1'b0;
                    nxt_done  = 1'b1;
                    nxt_st    = cies_pkg::ST_IDLE;
                end else begin
                    nxt_cnt = 13'(cnt_ff - 13'h0001);
                end
            end
            default: nxt_st = cies_pkg::ST_IDLE;
        endcase
        nxt_busy = (nxt_st != cies_pkg::ST_IDLE);
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= cies_pkg::SR_RESET;
            usp_ff    <= 32'h0000_0000;
            an_ff     <= '{default: 32'h0000_0000};
            sfc_ff    <= 3'h0;
            dfc_ff    <= 3'h0;
            st_ff     <= cies_pkg::ST_IDLE;
            res_ff    <= 32'h0000_0000;
            rhi_ff    <= 32'h0000_0000;
            anout_ff  <= 32'h0000_0000;
            done_ff   <= 1'b0;
            trap_ff   <= 1'b0;
            vec_ff    <= 8'h00;
            list_ff   <= 8'h00;
            fc_ff     <= 3'h0;
            idx_ff    <= 3'h0;
            we_ff     <= 1'b0;
            re_ff     <= 1'b0;
            rst_o_ff  <= 1'b0;
            cnt_ff    <= 13'h0000;
            prod_ff   <= 64'h0000_0000_0000_0000;
            full_ff   <= 1'b0;
            ld_ff     <= 1'b0;
            busy_ff   <= 1'b0;
        end else if (ce) begin
            status_ff <= nxt_status;
            usp_ff    <= nxt_usp;
            an_ff     <= nxt_an;
            sfc_ff    <= nxt_sfc;
            dfc_ff    <= nxt_dfc;
            st_ff     <= nxt_st;
            res_ff    <= nxt_res;
            rhi_ff    <= nxt_rhi;
            anout_ff  <= nxt_anout;
            done_ff   <= nxt_done;
            trap_ff   <= nxt_trap;
            vec_ff    <= nxt_vec;
            list_ff   <= nxt_list;
            fc_ff     <= nxt_fc;
            idx_ff    <= nxt_idx;
            we_ff     <= nxt_we;
            re_ff     <= nxt_re;
            rst_o_ff  <= nxt_rst_o;
            cnt_ff    <= nxt_cnt;
            prod_ff   <= nxt_prod;
            full_ff   <= nxt_full;
            ld_ff     <= nxt_ld;
            busy_ff   <= nxt_busy;
        end
    end

    // Outputs straight from flip-flops
    assign busy               = busy_ff;
    assign done               = done_ff;
    assign result             = res_ff;
    assign result_hi          = rhi_ff;
    assign trap               = trap_ff;
    assign trap_vector        = vec_ff;
    assign status_reg         = status_ff;
    assign user_stack_pointer = usp_ff;
    assign addr_reg_out       = anout_ff;
    assign mem_fc             = fc_ff;
    assign mem_we             = we_ff;
    assign mem_re             = re_ff;
    assign mem_reg_idx        = idx_ff;
    assign ext_reset          = rst_o_ff;

    // User-state privileged command leaves status untouched
    property priv_keep_p;
        @(posedge clk) disable iff (rst)
        (ce && cmd_valid && priv_op && !sup && st_ff == cies_pkg::ST_IDLE)
            |=> (trap_ff && vec_ff == cies_pkg::PRIV_VECTOR && $stable(status_ff)
                 && $stable(usp_ff) && !rst_o_ff);
    endproperty
    priv_trap_a: assert property (priv_keep_p) else $error("privilege trap wrong");
    sr_write_a: assert property (@(posedge clk) disable iff (rst)
        (ce && cmd_valid && sup && op == cies_pkg::OP_SR_WRITE && st_ff == cies_pkg::ST_IDLE)
        |=> status_ff == $past(src_data[15:0])) else $error("status write lost");
    neg_res_a: assert property (@(posedge clk) disable iff (rst)
        (ce && cmd_valid && op == cies_pkg::OP_NEG && st_ff == cies_pkg::ST_IDLE)
        |=> res_ff + $past(dst_data) == 32'h0000_0000) else $error("negate wrong");
    or_res_a: assert property (@(posedge clk) disable iff (rst)
        (ce && cmd_valid && op == cies_pkg::OP_OR && st_ff == cies_pkg::ST_IDLE)
        |=> res_ff == ($past(src_data) | $past(dst_data))) else $error("or wrong");
    sequence mul_start_s;
        ce && cmd_valid && op == cies_pkg::OP_UNSIGNED_MULTIPLY_W && st_ff == cies_pkg::ST_IDLE;
    endsequence
    mul_done_a: assert property (@(posedge clk) disable iff (rst)
        mul_start_s ##1 ce[*4] |=> done_ff) else $error("multiply late");
    reset_out_a: assert property (@(posedge clk) disable iff (rst)
        $rose(rst_o_ff) |-> sup) else $error("reset pulse from user");
    quick_res_a: assert property (@(posedge clk) disable iff (rst)
        (ce && cmd_valid && op == cies_pkg::OP_QUICK && st_ff == cies_pkg::ST_IDLE)
        |=> res_ff[31:7] == {25{res_ff[7]}}) else $error("quick sign wrong");
    alt_fc_a: assert property (@(posedge clk) disable iff (rst)
        (we_ff && done_ff) |->
        (mem_fc == $past(dfc_ff))) else $error("alternate fc wrong");
endmodule // cies_core

// [verilog/cies_pkg.sv]
// Package of constants and types for the instruction execution subset
package cies_pkg;
    localparam int          DATA_W        = 32;
    localparam int          NREG          = 8;
    localparam int          SUP_BIT       = 13;
    localparam logic [15:0] SR_RESET      = 16'h2700;
    localparam logic [7:0]  PRIV_VECTOR   = 8'h08;
    localparam int          XFLAG_BIT     = 4;
    localparam int          RESET_OUT_NS  = 6400;
    localparam int          CLK_NS        = 50;
    localparam int          RESET_OUT_CYC = RESET_OUT_NS / CLK_NS;
    localparam int          MUL_CYC       = 4;

    // Operation codes presented on the command port
    typedef enum logic [4:0] {
        OP_NONE      = 5'b0_0000,
        OP_SR_READ   = 5'b0_0001,
        OP_SR_WRITE  = 5'b0_0010,
        OP_USP_TO_AN = 5'b0_0011,
        OP_AN_TO_USP = 5'b0_0100,
        OP_ALT_WRITE = 5'b0_0101,
        OP_ALT_READ  = 5'b0_0110,
        OP_MULTI_ST  = 5'b0_0111,
        OP_MULTI_LD  = 5'b0_1000,
        OP_QUICK     = 5'b0_1001,
        OP_UNSIGNED_MULTIPLY_W    = 5'b0_1010,
        OP_SIGNED_MULTIPLY_W    = 5'b0_1011,
        OP_UNSIGNED_MULTIPLY_L    = 5'b0_1100,
        OP_SIGNED_MULTIPLY_L    = 5'b0_1101,
        OP_UNSIGNED_MULTIPLY_LL   = 5'b0_1110,
        OP_SIGNED_MULTIPLY_LL   = 5'b0_1111,
        OP_NEG       = 5'b1_0000,
        OP_NEGATE_EXTEND_OP      = 5'b1_0001,
        OP_OR        = 5'b1_0010,
        OP_ORI       = 5'b1_0011,
        OP_ORI_SR    = 5'b1_0100,
        OP_RESET     = 5'b1_0101,
        OP_ROL       = 5'b1_0110,
        OP_ROR       = 5'b1_0111
    } cies_op_e;

    // Execution state machine
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_MUL   = 2'b01,
        ST_MULTI = 2'b10,
        ST_RESET = 2'b11
    } cies_state_e;
endpackage

// [verilog/cies_rotator.sv]
// Rotator for register and memory operands
`timescale 1ns/100ps
module cies_rotator #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] din,   // Operand
    input  wire logic [5:0]   count, // Rotate count
    input  wire logic         left,  // Direction, high for left
    output logic      [W-1:0] dout   // Rotated result
);
    logic [2*W-1:0] dbl;
    logic [5:0]     amt;

    // Rotation through a doubled operand
    always_comb begin
        amt = 6'(count % 6'(W));
        dbl = {din, din};
        if (left) begin
            dout = dbl[2*W-1-amt -: W];
        end else begin
            dout = dbl[amt +: W];
        end
    end
endmodule // cies_rotator

// [bench/cies_core_tb.sv]
// Self-checking testbench for the instruction execution subset core
`timescale 1ns/100ps
module cies_core_tb;
    localparam int RCYC = 4;
    typedef struct packed {logic is_trap; logic chk; logic [31:0] res; logic chk_hi;
                           logic [31:0] hi;} cies_exp_s;
    typedef struct packed {logic we; logic [2:0] fc; logic [2:0] idx; logic chk_idx;} cies_beat_s;
    logic        clk, rst, ce, cmd_valid, mul_full, rot_mem, fc_we_src, fc_we_dst;
    logic [4:0]  cmd_op;
    logic [31:0] src_data, dst_data, seed;
    logic [2:0]  reg_sel, reg_hi_sel, fc_in;
    logic [7:0]  reg_list;
    logic [5:0]  rot_count;
    logic        busy, done, trap, mem_we, mem_re, ext_reset;
    logic [31:0] result, result_hi, user_stack_pointer, addr_reg_out, usp_snap;
    logic [7:0]  trap_vector;
    logic [15:0] status_reg;
    logic [2:0]  mem_fc, mem_reg_idx;
    int          miscompares = 0, n_checks = 0, rcnt = 0, pulses = 0;
    bit          loose = 0;
    cies_exp_s   q[$];
    cies_beat_s  mq[$];
    cies_pkg::cies_op_e ops[13] = '{cies_pkg::OP_QUICK, cies_pkg::OP_UNSIGNED_MULTIPLY_W, cies_pkg::OP_SIGNED_MULTIPLY_W,
        cies_pkg::OP_UNSIGNED_MULTIPLY_L, cies_pkg::OP_SIGNED_MULTIPLY_L, cies_pkg::OP_UNSIGNED_MULTIPLY_LL, cies_pkg::OP_SIGNED_MULTIPLY_LL,
        cies_pkg::OP_NEG, cies_pkg::OP_NEGATE_EXTEND_OP, cies_pkg::OP_OR, cies_pkg::OP_ORI,
        cies_pkg::OP_ROL, cies_pkg::OP_ROR};
    cies_pkg::cies_op_e priv[8] = '{cies_pkg::OP_SR_READ, cies_pkg::OP_SR_WRITE,
        cies_pkg::OP_USP_TO_AN, cies_pkg::OP_AN_TO_USP, cies_pkg::OP_ALT_WRITE,
        cies_pkg::OP_ALT_READ, cies_pkg::OP_ORI_SR, cies_pkg::OP_RESET};

    cies_core #(.RESET_CYC(RCYC)) u_dut (.clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .src_data(src_data), .dst_data(dst_data), .reg_sel(reg_sel),
        .reg_hi_sel(reg_hi_sel), .mul_full(mul_full), .reg_list(reg_list),
        .rot_count(rot_count), .rot_mem(rot_mem), .fc_in(fc_in), .fc_we_src(fc_we_src),
        .fc_we_dst(fc_we_dst), .busy(busy), .done(done), .result(result),
        .result_hi(result_hi), .trap(trap), .trap_vector(trap_vector),
        .status_reg(status_reg), .user_stack_pointer(user_stack_pointer),
        .addr_reg_out(addr_reg_out), .mem_fc(mem_fc), .mem_we(mem_we), .mem_re(mem_re),
        .mem_reg_idx(mem_reg_idx), .ext_reset(ext_reset));

    // Clock at 20 MHz
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_flag(input string nm, input logic e, input logic g);
        cmp_word(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic close_out;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Next pseudo-random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected outcome of a non-privileged operation
    function automatic cies_exp_s calc(input cies_pkg::cies_op_e op, input logic [31:0] s, d,
                                       input logic [4:0] n, input logic m, input logic x);
        cies_exp_s e;
        logic signed [63:0] p;
        logic [5:0] k;
        e = '0;
        e.chk = 1'b1;
        k = m ? 6'd1 : {1'b0, n};
        case (op)
            cies_pkg::OP_QUICK:  e.res = {{24{s[7]}}, s[7:0]};
            cies_pkg::OP_UNSIGNED_MULTIPLY_W: e.res = s[15:0] * d[15:0];
            cies_pkg::OP_SIGNED_MULTIPLY_W: e.res = $signed(s[15:0]) * $signed(d[15:0]);
            cies_pkg::OP_UNSIGNED_MULTIPLY_L, cies_pkg::OP_SIGNED_MULTIPLY_L: e.res = s * d;
            cies_pkg::OP_UNSIGNED_MULTIPLY_LL, cies_pkg::OP_SIGNED_MULTIPLY_LL: begin
                if (op == cies_pkg::OP_SIGNED_MULTIPLY_LL)
                    p = $signed(s) * $signed(d);
                else
                    p = {32'h0, s} * {32'h0, d};
                e.res = p[31:0];
                e.hi = p[63:32];
                e.chk_hi = 1'b1;
            end
            cies_pkg::OP_NEG:  e.res = 32'h0 - d;
            cies_pkg::OP_NEGATE_EXTEND_OP: e.res = 32'h0 - d - {31'h0, x};
            cies_pkg::OP_OR, cies_pkg::OP_ORI: e.res = s | d;
            cies_pkg::OP_ROL: begin
                p = {d, d} << k;
                e.res = p[63:32];
            end
            cies_pkg::OP_ROR: begin
                p = {d, d} >> k;
                e.res = p[31:0];
            end
            default: e.chk = 1'b0;
        endcase
        return e;
    endfunction

    // Present one command, note its outcome, wait until it has been seen
    task automatic issue(input cies_pkg::cies_op_e op, input logic [31:0] s, d,
                         input cies_exp_s e, input bit push, input logic [7:0] rl,
                         input logic [4:0] rc, input logic rm);
        int i;
        if (push)
            q.push_back(e);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        src_data <= s;
        dst_data <= d;
        reg_list <= rl;
        rot_count <= {1'b0, rc};
        rot_mem <= rm;
        mul_full <= (op == cies_pkg::OP_UNSIGNED_MULTIPLY_LL || op == cies_pkg::OP_SIGNED_MULTIPLY_LL);
        reg_sel <= seed[2:0];
        reg_hi_sel <= seed[5:3];
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(negedge clk);
            if (busy === 1'b0 && q.size() == 0 && mq.size() == 0)
                break;
        end
        if (i == 300) begin
            miscompares++;
            $display("CHECK FAILED completion expected 1 seen 0");
        end
    endtask

    // Result and trap monitor
    always @(negedge clk) begin
        cies_exp_s e;
        cies_beat_s b;
        if (!rst && (done === 1'b1 || trap === 1'b1)) begin
            if (q.size() > 0) begin
                e = q.pop_front();
                cmp_flag("trap", e.is_trap, trap);
                if (e.is_trap) cmp_word("vector", {24'h0, cies_pkg::PRIV_VECTOR},
                                        {24'h0, trap_vector});
                if (e.chk) cmp_word("result", e.res, result);
                if (e.chk_hi) cmp_word("result_hi", e.hi, result_hi);
            end else if (!loose || trap === 1'b1)
                cmp_flag("unexpected completion", 1'b0, 1'b1);
        end
        if (!rst && (mem_we === 1'b1 || mem_re === 1'b1)) begin
            if (mq.size() > 0) begin
                b = mq.pop_front();
                cmp_flag("mem_we", b.we, mem_we);
                cmp_word("mem_fc", {29'h0, b.fc}, {29'h0, mem_fc});
                if (b.chk_idx) cmp_word("mem_reg_idx", {29'h0, b.idx}, {29'h0, mem_reg_idx});
            end else
                cmp_flag("unexpected memory beat", 1'b0, 1'b1);
        end
        if (ext_reset === 1'b1)
            rcnt++;
        else if (rcnt != 0) begin
            cmp_word("ext_reset width", RCYC, rcnt);
            rcnt = 0;
            pulses++;
        end
    end

    // Watchdog
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end

    // Main sequence
    initial begin
        cies_exp_s e, t;
        logic [7:0] lists[3];
        logic [15:0] sr;
        logic [4:0] rc;
        logic rm;
        {rst, ce, cmd_valid, mul_full, rot_mem, fc_we_src, fc_we_dst} = 7'b1100000;
        {cmd_op, src_data, dst_data, reg_sel, reg_hi_sel, fc_in, reg_list, rot_count} = '0;
        seed = 32'h0000_0010;
        t = '0;
        t.is_trap = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cmp_word("status reset", {16'h0, cies_pkg::SR_RESET}, {16'h0, status_reg});
        sr = cies_pkg::SR_RESET | 16'h0010;
        issue(cies_pkg::OP_ORI_SR, 32'h0000_0010, 32'h0, '0, 1, 8'h00, 5'd0, 1'b0);
        cmp_word("status ori", {16'h0, sr}, {16'h0, status_reg});
        e = '0;
        e.chk = 1'b1;
        e.res = {16'h0, sr};
        issue(cies_pkg::OP_SR_READ, 32'h0, 32'h0, e, 1, 8'h00, 5'd0, 1'b0);
        for (int pass = 0; pass < 4; pass++) begin
            if (pass == 3) begin
                sr = cies_pkg::SR_RESET;
                issue(cies_pkg::OP_SR_WRITE, {16'h0, sr}, 32'h0, '0, 1, 8'h00, 5'd0, 1'b0);
                cmp_word("status write", {16'h0, sr}, {16'h0, status_reg});
            end
            foreach (ops[i]) begin
                seed = lfsr(seed);
                src_data = seed;
                seed = lfsr(lfsr(seed));
                rc = (pass == 0) ? 5'd0 : (pass == 1) ? 5'd31 : seed[12:8];
                rm = (pass == 2) & seed[3];
                issue(ops[i], src_data, seed, calc(ops[i], src_data, seed, rc, rm, sr[4]), 1,
                      8'h00, rc, rm);
            end
        end
        lists = '{8'hFF, 8'h01, seed[7:0] | 8'h10};
        foreach (lists[i]) begin
            for (int d = 0; d < 2; d++) begin
                for (int r = 0; r < 8; r++)
                    if (lists[i][r]) mq.push_back({d == 0, 3'd5, 3'(r), 1'b1});
                issue(d == 0 ? cies_pkg::OP_MULTI_ST : cies_pkg::OP_MULTI_LD, seed, 32'h0, '0,
                      1, lists[i], 5'd0, 1'b0);
            end
        end
        @(posedge clk);
        fc_in <= 3'd6;
        fc_we_dst <= 1'b1;
        @(posedge clk);
        fc_in <= 3'd2;
        fc_we_dst <= 1'b0;
        fc_we_src <= 1'b1;
        @(posedge clk);
        fc_we_src <= 1'b0;
        loose = 1;
        mq.push_back({1'b1, 3'd6, 3'd0, 1'b0});
        issue(cies_pkg::OP_ALT_WRITE, seed, 32'h0, '0, 0, 8'h00, 5'd0, 1'b0);
        mq.push_back({1'b0, 3'd2, 3'd0, 1'b0});
        issue(cies_pkg::OP_ALT_READ, seed, 32'h0, '0, 0, 8'h00, 5'd0, 1'b0);
        repeat (3) @(negedge clk);
        loose = 0;
        issue(cies_pkg::OP_AN_TO_USP, seed, 32'h0, '0, 1, 8'h00, 5'd0, 1'b0);
        issue(cies_pkg::OP_USP_TO_AN, seed, 32'h0, '0, 1, 8'h00, 5'd0, 1'b0);
        issue(cies_pkg::OP_RESET, 32'h0, 32'h0, '0, 1, 8'h00, 5'd0, 1'b0);
        cmp_word("reset pulses", 32'd1, pulses);
        issue(cies_pkg::OP_SR_WRITE, 32'h0, 32'h0, '0, 1, 8'h00, 5'd0, 1'b0);
        usp_snap = user_stack_pointer;
        foreach (priv[i]) begin
            issue(priv[i], 32'hFFFF_FFFF, 32'h0, t, 1, 8'h00, 5'd0, 1'b0);
            cmp_word("status user", 32'h0, {16'h0, status_reg});
            cmp_word("usp user", usp_snap, user_stack_pointer);
        end
        cmp_word("reset pulses user", 32'd1, pulses);
        @(posedge clk);
        ce <= 1'b0;
        issue(cies_pkg::OP_OR, 32'h1, 32'h2, '0, 0, 8'h00, 5'd0, 1'b0);
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        issue(cies_pkg::OP_OR, 32'h1, 32'h2, calc(cies_pkg::OP_OR, 32'h1, 32'h2, 5'd0, 1'b0,
              1'b0), 1, 8'h00, 5'd0, 1'b0);
        close_out();
    end
endmodule // cies_core_tb
